// *** rtl/adccfg_regs.svh ***
// Constants for the serial configuration front end: fields, resets, timing
`ifndef ADCCFG_REGS_SVH
`define ADCCFG_REGS_SVH

// ---------------------------------------------------------------------
// Frame layout
// ---------------------------------------------------------------------
`define ADCCFG_FRAME_BITS      5'd16
`define ADCCFG_TRACK_EDGE      5'd14
`define ADCCFG_WRITE_BIT       15
`define ADCCFG_SEL_MSB         14
`define ADCCFG_SEL_LSB         13
`define ADCCFG_CTL_MSB         12
`define ADCCFG_CTL_LSB         1
`define ADCCFG_BYTE_MSB        12
`define ADCCFG_BYTE_LSB        5

// ---------------------------------------------------------------------
// Register select codes
// ---------------------------------------------------------------------
`define ADCCFG_SEL_CTL         2'h0
`define ADCCFG_SEL_RANGE1      2'h1
`define ADCCFG_SEL_RANGE2      2'h2
`define ADCCFG_SEL_SEQ         2'h3

// ---------------------------------------------------------------------
// Power-up values
// ---------------------------------------------------------------------
`define ADCCFG_CTL_RESET       12'h000
`define ADCCFG_RANGE_RESET     8'h00
`define ADCCFG_SEQ_RESET       8'h00

// ---------------------------------------------------------------------
// Sequencer and power codes
// ---------------------------------------------------------------------
`define ADCCFG_SEQ_LIST        2'h1
`define ADCCFG_SEQ_UPTO        2'h2
`define ADCCFG_PWR_NORMAL      2'h0
`define ADCCFG_PWR_FULL_OFF    2'h3

// ---------------------------------------------------------------------
// Full-scale span divisor, one code step is span / 8192
// ---------------------------------------------------------------------
`define ADCCFG_CODE_STEPS      14'h2000

`endif

// *** rtl/adccfg_pkg.sv ***
// Types shared by the serial configuration front end
package adccfg_pkg;

  // -------------------------------------------------------------------
  // Control register layout, MSB first as shifted
  // -------------------------------------------------------------------
  typedef struct packed {
    logic [2:0] chan_sel;
    logic [1:0] input_cfg;
    logic [1:0] power_sel;
    logic       coding_straight;
    logic       ref_internal;
    logic       sequencer_sel_a;
    logic       sequencer_sel_b;
    logic       line_weak;
  } adccfg_setup_t;

  typedef enum logic [1:0] {
    ADCCFG_IDLE,
    ADCCFG_SHIFT,
    ADCCFG_DONE
  } adccfg_phase_t;

  // -------------------------------------------------------------------
  // State of the top module, apart from the reset, power and step registers
  // -------------------------------------------------------------------
  typedef struct packed {
    logic          sclk_q;
    logic          cs_n_q;
    adccfg_phase_t phase;
    logic [4:0]    fall_cnt;
    logic [4:0]    rise_cnt;
    logic [15:0]   shreg;
    adccfg_setup_t setup;
    logic [7:0]    range_lo;
    logic [7:0]    range_hi;
    logic [7:0]    seq_flags;
    logic [2:0]    active_chan;
    logic [1:0]    active_range;
    logic          tracking;
    logic          frame_done;
    logic          dout;
    logic          dout_oe;
  } adccfg_state_t;

endpackage

// *** rtl/adccfg_sync.sv ***
// Two-stage synchroniser for a group of asynchronous levels
`timescale 1ns/1ps
`default_nettype none

module adccfg_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Levels
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);

  logic [W-1:0] meta;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule

`default_nettype wire

// *** rtl/adccfg_top.sv ***
// Serial configuration front end of an eight-channel converter
//
// Behaviour
// (RULE_01) Coding is two's complement unless bit set
// (RULE_02) Sequence channels use last written coding bit
// (RULE_03) Code step is selected span over 8192
// (RULE_04) Inputs start single-ended; host picks differential
// (RULE_05) Tracking starts on 14th rising clock edge
// (RULE_06) Hold resumes at next chip select fall
// (RULE_07) Converter range follows selected channel's code
// (RULE_08) Four write-only registers, none read back
// (RULE_09) Frames are 16 clocks, MSB first
// (RULE_10) First three bits: write flag, two selects
// (RULE_11) Write flag zero leaves every register alone
// (RULE_12) Select 00 loads twelve control bits
// (RULE_13) Select 01 loads range for channels 0-3
// (RULE_14) Select 10 loads range for channels 4-7
// (RULE_15) Select 11 loads eight sequence bits
// (RULE_16) Control bits set up the next conversion
// (RULE_17) Host writes range, sequence before control
// (RULE_18) Control powers up zero; fixed bit order
// (RULE_19) Two-bit range code per channel, default 10V
// (RULE_20) Sequencer codes pick list, upto or single
// (RULE_21) Power code selects normal, standby, shutdown
// (RULE_22) Line bit set weakly drives next channel MSB
// (RULE_23) Bits after a payload are ignored
`timescale 1ns/1ps
`default_nettype none
`include "adccfg_regs.svh"

module adccfg_top (
  // Clock and power-up reset
  input  wire logic                  core_clk,
  input  wire logic                  rst_n,
  // Serial link from the host
  input  wire logic                  sclk,
  input  wire logic                  cs_n,
  input  wire logic                  din,
  // Serial output pin, weak keeper drive
  output var  logic                  dout_o,
  output var  logic                  dout_oe,
  // Conversion setup
  output var  adccfg_pkg::adccfg_setup_t setup,
  output var  logic [2:0]            active_chan,
  output var  logic [1:0]            active_range,
  output var  logic [13:0]           code_steps,
  output var  logic                  core_powered,
  output var  logic                  ref_powered,
  // Track-and-hold and frame status
  output var  logic                  tracking,
  output var  logic                  frame_done
);

  // -------------------------------------------------------------------
  // Reset release and pin synchronisers
  // -------------------------------------------------------------------
  logic       rst_meta;
  logic       rst_sync_n;
  logic [2:0] pins_s;
  logic       sclk_s;
  logic       cs_n_s;
  logic       din_s;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta   <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta   <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  adccfg_sync #(
    .W (3)
  ) u_pin_sync (
    .clk   (core_clk),
    .rst_n (rst_sync_n),
    .d     ({sclk, cs_n, din}),
    .q     (pins_s)
  );

  assign sclk_s = pins_s[2];
  assign cs_n_s = pins_s[1];
  assign din_s  = pins_s[0];

  // -------------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------------
  // Next flagged channel above cur, wrapping; cur kept if none flagged
  function automatic logic [2:0] seq_next(input logic [2:0] cur,
                                          input logic [7:0] flags);
    logic [2:0] idx;
    logic       found;
    logic [2:0] res;
    found = 1'b0;
    res   = cur;
    for (int i = 1; i <= 8; i++) begin
      idx = 3'(cur + 3'(i));
      // Flag for channel 0 sits in the MSB
      if (!found && flags[3'h7 - idx]) begin
        found = 1'b1;
        res   = idx;
      end
    end
    return res;
  endfunction

  function automatic logic [1:0] range_of(input logic [2:0] ch,
                                          input logic [7:0] lo,
                                          input logic [7:0] hi);
    logic [7:0] r;
    logic [1:0] pos;
    r   = ch[2] ? hi : lo;
    pos = 2'h3 - ch[1:0];
    return r[{pos, 1'b0} +: 2];
  endfunction

  // Channel for the next conversion after a control write
  function automatic logic [2:0] first_chan(
      input adccfg_pkg::adccfg_setup_t s,
      input logic [7:0]                flags);
    logic [1:0] mode;
    mode = {s.sequencer_sel_a, s.sequencer_sel_b};
    case (mode)
      `ADCCFG_SEQ_LIST: return seq_next(3'h7, flags);
      `ADCCFG_SEQ_UPTO: return 3'h0;
      default:          return s.chan_sel;
    endcase
  endfunction

  // Channel for the following conversion without a control write
  function automatic logic [2:0] step_chan(
      input adccfg_pkg::adccfg_setup_t s,
      input logic [2:0]                cur,
      input logic [7:0]                flags);
    logic [1:0] mode;
    mode = {s.sequencer_sel_a, s.sequencer_sel_b};
    case (mode)
      `ADCCFG_SEQ_LIST: return seq_next(cur, flags);
      `ADCCFG_SEQ_UPTO: return (cur >= s.chan_sel) ? 3'h0 : 3'(cur + 3'h1);
      default:          return s.chan_sel;
    endcase
  endfunction

  // -------------------------------------------------------------------
  // State
  // -------------------------------------------------------------------
  adccfg_pkg::adccfg_state_t st;
  adccfg_pkg::adccfg_state_t next_st;

  logic        sclk_rise;
  logic        sclk_fall;
  logic        cs_fall;
  logic        cs_rise;
  logic [15:0] word;
  logic [1:0]  sel;

  always_comb begin
    sclk_rise = sclk_s & ~st.sclk_q;
    sclk_fall = ~sclk_s & st.sclk_q;
    cs_fall   = ~cs_n_s & st.cs_n_q;
    cs_rise   = cs_n_s & ~st.cs_n_q;
    word      = {st.shreg[14:0], din_s};
    sel       = word[`ADCCFG_SEL_MSB:`ADCCFG_SEL_LSB];

    next_st            = st;
    next_st.sclk_q     = sclk_s;
    next_st.cs_n_q     = cs_n_s;
    next_st.frame_done = 1'b0;

    case (st.phase)
      adccfg_pkg::ADCCFG_IDLE: begin
        if (cs_fall) begin
          next_st.phase    = adccfg_pkg::ADCCFG_SHIFT;
          next_st.fall_cnt = 5'h00;
          next_st.rise_cnt = 5'h00;
          next_st.shreg    = 16'h0000;
          next_st.tracking = 1'b0;  // see (RULE_06)
          next_st.dout_oe  = 1'b0;
        end
      end
      adccfg_pkg::ADCCFG_SHIFT: begin
        if (cs_rise) begin
          // Short frame is dropped, registers untouched
          next_st.phase = adccfg_pkg::ADCCFG_IDLE;
        end else begin
          if (sclk_rise && st.rise_cnt != 5'h1F) begin
            next_st.rise_cnt = 5'(st.rise_cnt + 5'h01);
            if (5'(st.rise_cnt + 5'h01) == `ADCCFG_TRACK_EDGE) begin
              next_st.tracking = 1'b1;  // see (RULE_05)
            end
          end
          if (sclk_fall) begin
            // MSB first shift of the data line, see (RULE_09)
            next_st.shreg    = word;
            next_st.fall_cnt = 5'(st.fall_cnt + 5'h01);
            if (5'(st.fall_cnt + 5'h01) == `ADCCFG_FRAME_BITS) begin
              next_st.phase      = adccfg_pkg::ADCCFG_DONE;
              next_st.frame_done = 1'b1;
              // Registers are write only, see (RULE_08)
              if (word[`ADCCFG_WRITE_BIT]) begin  // see (RULE_11)
                case (sel)  // see (RULE_10)
                  `ADCCFG_SEL_CTL: begin
                    // Trailing bit 0 dropped, see (RULE_12) (RULE_18)
                    next_st.setup =
                      word[`ADCCFG_CTL_MSB:`ADCCFG_CTL_LSB];
                    // Host loads range and sequence first, see (RULE_17)
                    next_st.active_chan =
                      first_chan(next_st.setup, st.seq_flags);
                  end
                  `ADCCFG_SEL_RANGE1: begin
                    next_st.range_lo =
                      word[`ADCCFG_BYTE_MSB:`ADCCFG_BYTE_LSB];  // see (RULE_13)
                  end
                  `ADCCFG_SEL_RANGE2: begin
                    next_st.range_hi =
                      word[`ADCCFG_BYTE_MSB:`ADCCFG_BYTE_LSB];  // see (RULE_14)
                  end
                  `ADCCFG_SEL_SEQ: begin
                    next_st.seq_flags =
                      word[`ADCCFG_BYTE_MSB:`ADCCFG_BYTE_LSB];  // see (RULE_15)
                  end
                  default: begin
                    next_st.seq_flags = st.seq_flags;
                  end
                endcase
              end
              if (!(word[`ADCCFG_WRITE_BIT] && sel == `ADCCFG_SEL_CTL)) begin
                // Coding and setup carry over, see (RULE_02) (RULE_20)
                next_st.active_chan =
                  step_chan(st.setup, st.active_chan, st.seq_flags);
              end
            end
          end
        end
      end
      adccfg_pkg::ADCCFG_DONE: begin
        // Extra clocks after the payload do nothing, see (RULE_23)
        if (cs_rise) begin
          next_st.phase = adccfg_pkg::ADCCFG_IDLE;
          // Weak keeper on next channel MSB, else float, see (RULE_22)
          next_st.dout_oe = st.setup.line_weak;
          next_st.dout    = st.active_chan[2];
        end else if (sclk_rise && st.rise_cnt != 5'h1F) begin
          next_st.rise_cnt = 5'(st.rise_cnt + 5'h01);
          if (5'(st.rise_cnt + 5'h01) == `ADCCFG_TRACK_EDGE) begin
            next_st.tracking = 1'b1;  // see (RULE_05)
          end
        end
      end
      default: begin
        next_st.phase = adccfg_pkg::ADCCFG_IDLE;
      end
    endcase

    // Range follows the channel in use, see (RULE_07) (RULE_19)
    next_st.active_range = range_of(next_st.active_chan,
                                    next_st.range_lo, next_st.range_hi);
  end

  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      // Match the synchroniser's reset level, no false select edge
      st.sclk_q       <= 1'b0;
      st.cs_n_q       <= 1'b0;
      st.phase        <= adccfg_pkg::ADCCFG_IDLE;
      st.fall_cnt     <= 5'h00;
      st.rise_cnt     <= 5'h00;
      st.shreg        <= 16'h0000;
      // Single-ended, two's complement at power-up, see (RULE_01) (RULE_04)
      st.setup        <= `ADCCFG_CTL_RESET;  // see (RULE_18)
      st.range_lo     <= `ADCCFG_RANGE_RESET;  // see (RULE_19)
      st.range_hi     <= `ADCCFG_RANGE_RESET;
      st.seq_flags    <= `ADCCFG_SEQ_RESET;
      st.active_chan  <= 3'h0;
      st.active_range <= 2'h0;
      st.tracking     <= 1'b0;
      st.frame_done   <= 1'b0;
      st.dout         <= 1'b0;
      st.dout_oe      <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // -------------------------------------------------------------------
  // Power state and step size, registered for clean outputs
  // -------------------------------------------------------------------
  logic        next_core_powered;
  logic        next_ref_powered;
  logic [13:0] next_code_steps;

  always_comb begin
    // Auto modes power down between frames only, see (RULE_21)
    case (st.setup.power_sel)
      `ADCCFG_PWR_NORMAL: begin
        next_core_powered = 1'b1;
        next_ref_powered  = 1'b1;
      end
      `ADCCFG_PWR_FULL_OFF: begin
        next_core_powered = 1'b0;
        next_ref_powered  = 1'b0;
      end
      default: begin
        next_core_powered = (st.phase != adccfg_pkg::ADCCFG_IDLE);
        next_ref_powered  = next_core_powered | ~st.setup.power_sel[1];
      end
    endcase
    // Span is divided into this many steps for every range, see (RULE_03)
    next_code_steps = `ADCCFG_CODE_STEPS;
  end

  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      core_powered <= 1'b1;
      ref_powered  <= 1'b1;
      code_steps   <= `ADCCFG_CODE_STEPS;
    end else begin
      core_powered <= next_core_powered;
      ref_powered  <= next_ref_powered;
      code_steps   <= next_code_steps;
    end
  end

  // -------------------------------------------------------------------
  // Outputs straight from state
  // -------------------------------------------------------------------
  // Coding bit feeds every conversion, see (RULE_01) (RULE_16)
  assign setup        = st.setup;
  assign active_chan  = st.active_chan;
  assign active_range = st.active_range;
  assign tracking     = st.tracking;
  assign frame_done   = st.frame_done;
  assign dout_o       = st.dout;
  assign dout_oe      = st.dout_oe;

endmodule

`default_nettype wire

// *** verif/adccfg_checker_assertions.sv ***
// Port-level concurrent checks for the configuration front end
`timescale 1ns/1ps
`default_nettype none

module adccfg_checker (
  // Clock and reset
  input wire logic                      core_clk,
  input wire logic                      rst_n,
  // Link from the host
  input wire logic                      sclk,
  input wire logic                      cs_n,
  // Outputs watched
  input wire logic                      dout_oe,
  input wire adccfg_pkg::adccfg_setup_t setup,
  input wire logic [1:0]                active_range,
  input wire logic [13:0]               code_steps,
  input wire logic                      core_powered,
  input wire logic                      ref_powered,
  input wire logic                      tracking,
  input wire logic                      frame_done
);
  logic       sclk_q;
  logic [4:0] rise_cnt;
  logic [4:0] fall_cnt;

  // Raw edge counts inside a frame; the design trails them by 2 clocks
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_q   <= 1'b1;
      rise_cnt <= 5'h00;
      fall_cnt <= 5'h00;
    end else begin
      sclk_q <= sclk;
      if (cs_n) begin
        rise_cnt <= 5'h00;
        fall_cnt <= 5'h00;
      end else begin
        if (sclk && !sclk_q) rise_cnt <= rise_cnt + 5'h01;
        if (!sclk && sclk_q) fall_cnt <= fall_cnt + 5'h01;
      end
    end
  end

  // ----
  // Assertions
  // ----
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_cs_fall;
    $fell(cs_n);
  endsequence
  sequence s_hold_soon;
    ##[1:5] !tracking;
  endsequence

  a_track_rise: assert property ($rose(tracking) |-> rise_cnt == 5'h0E)
    else $error("tracking rose on the wrong clock edge");
  a_hold_on_cs: assert property (s_cs_fall |-> s_hold_soon)
    else $error("tracking still high after chip select fell");
  a_done_pulse: assert property (frame_done |=> !frame_done)
    else $error("frame done longer than one cycle");
  a_done_count: assert property (frame_done |-> fall_cnt == 5'h10)
    else $error("frame done without sixteen clocks");
  a_setup_write: assert property ($changed(setup) |-> frame_done)
    else $error("setup changed outside a frame end");
  a_range_write: assert property ($changed(active_range) |-> frame_done)
    else $error("range changed outside a frame end");
  a_steps_fixed: assert property (code_steps == 14'h2000)
    else $error("code step count wrong");
  a_oe_off: assert property (s_cs_fall |-> ##[1:5] !dout_oe)
    else $error("output still driven in a frame");
  a_oe_level: assert property ($rose(cs_n) |-> ##[2:5] dout_oe == setup.line_weak)
    else $error("output drive does not follow line bit");
  a_full_off: assert property ((setup.power_sel == 2'h3) [*2] |-> !core_powered && !ref_powered)
    else $error("powered while in full shutdown");
  a_normal_on: assert property ((setup.power_sel == 2'h0) [*2] |-> core_powered && ref_powered)
    else $error("unpowered in normal mode");
endmodule

bind adccfg_top adccfg_checker adccfg_checker_i (
  .core_clk(core_clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n),
  .dout_oe(dout_oe), .setup(setup), .active_range(active_range),
  .code_steps(code_steps), .core_powered(core_powered),
  .ref_powered(ref_powered), .tracking(tracking), .frame_done(frame_done)
);

`default_nettype wire

// *** verif/adccfg_host.sv ***
// Serial master model that shifts configuration frames into the block
`timescale 1ns/1ps
`default_nettype none

module adccfg_host (
  // Link towards the block
  output var logic sclk,
  output var logic cs_n,
  output var logic din
);
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    din  = 1'b0;
  end

  // ----
  // One frame, MSB first; fewer than 16 clocks aborts it
  // ----
  // Clock stands high between frames; data shows its inverse when released
  task automatic xfer(input logic [15:0] w, input int n);
    #37;
    cs_n = 1'b0;
    din  = w[15];
    #400;
    for (int i = 0; i < n; i++) begin
      sclk = 1'b0;
      #400;
      sclk = 1'b1;
      din  = (i < 15) ? w[14-i] : ~din;
      #400;
    end
    cs_n = 1'b1;
    din  = ~din;
  endtask
endmodule

`default_nettype wire

// *** verif/adccfg_tb_top.sv ***
// Self-checking bench for the serial configuration front end
`timescale 1ns/1ps
`default_nettype none

module adccfg_tb_top;
  logic                      core_clk;
  logic                      rst_n;
  logic                      sclk;
  logic                      cs_n;
  logic                      din;
  logic                      dout_o;
  logic                      dout_oe;
  adccfg_pkg::adccfg_setup_t setup;
  logic [2:0]                active_chan;
  logic [1:0]                active_range;
  logic [13:0]               code_steps;
  logic                      core_powered;
  logic                      ref_powered;
  logic                      tracking;
  logic                      frame_done;
  int                        error_cnt;
  int                        checks_done;
  int                        cycles = 0;
  int                        ctl, r1, r2, sq, ach;

  adccfg_top adccfg_top_i (
    .core_clk(core_clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n),
    .din(din), .dout_o(dout_o), .dout_oe(dout_oe), .setup(setup),
    .active_chan(active_chan), .active_range(active_range),
    .code_steps(code_steps), .core_powered(core_powered),
    .ref_powered(ref_powered), .tracking(tracking), .frame_done(frame_done)
  );

  adccfg_host adccfg_host_i (.sclk(sclk), .cs_n(cs_n), .din(din));

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // ----
  // Reference model
  // ----
  function automatic int flag(input int c);
    return (sq >> (7 - c)) & 1;
  endfunction

  function automatic int rng(input int c);
    return c < 4 ? (r1 >> (6 - 2 * c)) & 3 : (r2 >> (14 - 2 * c)) & 3;
  endfunction

  // Channel advance on a complete frame that is not a control write
  task automatic step();
    int s;
    s = (ctl >> 1) & 3;
    if (s == 1) begin
      for (int k = 1; k <= 8; k++) begin
        if (flag((ach + k) % 8) == 1) begin
          ach = (ach + k) % 8;
          break;
        end
      end
    end else if (s == 2) begin
      ach = (ach == (ctl >> 9)) ? 0 : ach + 1;
    end else begin
      ach = ctl >> 9;
    end
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %0t seen %h exp %h", $time, seen, exp);
    end
  endtask

  task automatic frame(input logic [15:0] w, input int n);
    int p;
    @(negedge core_clk);
    adccfg_host_i.xfer(w, n);
    repeat (6) @(negedge core_clk);
    if (n == 16 && w[15] && w[14:13] == 2'h0) begin
      ctl = w[12:1];
      if (((ctl >> 1) & 3) == 1) begin
        ach = 7;
        step();
      end else begin
        ach = (((ctl >> 1) & 3) == 2) ? 0 : ctl >> 9;
      end
    end else if (n == 16) begin
      if (w[15] && w[14:13] == 2'h1) r1 = w[12:5];
      if (w[15] && w[14:13] == 2'h2) r2 = w[12:5];
      if (w[15] && w[14:13] == 2'h3) sq = w[12:5];
      step();
    end
    p = (ctl >> 5) & 3;
    chk(setup, ctl);
    chk(active_chan, ach);
    chk(active_range, rng(ach));
    chk(tracking, n >= 14);
    chk(dout_oe, n == 16 ? ctl & 1 : 0);
    if (dout_oe === 1'b1) chk(dout_o, ach >> 2);
    chk(core_powered, p == 0);
    chk(ref_powered, p < 2);
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Hang guard, about five times the expected run
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      test_done();
    end
  end

  // ----
  // Main sequence
  // ----
  initial begin
    rst_n = 1'b0;
    error_cnt = 0;
    checks_done = 0;
    ctl = 0;
    r1 = 0;
    r2 = 0;
    sq = 0;
    ach = 0;
    void'($urandom(32'hEF9A));
    repeat (4) @(negedge core_clk);
    rst_n = 1'b1;
    repeat (8) @(negedge core_clk);
    chk(setup, 12'h000);
    chk(active_range, 2'h0);
    chk(tracking, 1'b0);
    chk(core_powered, 1'b1);
    // Ranges and sequence go in before the control word
    frame({3'h5, 13'($urandom)}, 16);
    frame({3'h6, 13'($urandom)}, 16);
    frame({3'h7, 8'($urandom) | 8'h01, 5'($urandom)}, 16);
    frame({1'b0, 15'($urandom)}, 16);
    frame({3'h5, 13'($urandom)}, 10);
    for (int i = 0; i < 8; i++) begin
      frame({3'h4, 5'($urandom), 2'(i), 2'($urandom), 2'(i / 2),
             2'($urandom)}, 16);
      frame({3'h5, 13'($urandom)}, 16);
      frame({1'b0, 15'($urandom)}, 16);
    end
    test_done();
  end
endmodule

`default_nettype wire
